// *** core/port_sel_consts.vh ***
// constants for the host port selection and fifo reset logic
`ifndef PORT_SEL_CONSTS_VH
`define PORT_SEL_CONSTS_VH

// consecutive reset-match cycles before a fifo reset starts
`define RST_SEQ_LEN      4'h8
`define RST_CNT_W        4
// character clock divider used when the receive clock pin is an output
`define CHAR_DIV_DEF     8'h04
`define CHAR_DIV_W       8
`define DATA_W_DEF       12
`define BUF_PTR_ONE      1'b1

`endif

// *** core/fifo_reset_seq.v ***
// match state tracker and eight-cycle fifo reset sequencer for one interface
`timescale 1ns/100ps
`include "port_sel_consts.vh"

module fifo_reset_seq
(
    input  wire clk,
    input  wire rst_n,
    input  wire edge_en,
    input  wire am_n,
    input  wire sel_n,
    input  wire hold,
    input  wire block,
    output reg  match_r,
    output reg  rmatch_r,
    output reg  forced_r,
    output reg  clear_r
);

    // ----------------------------------------
    // state and counter
    // ----------------------------------------
    reg [`RST_CNT_W-1:0] cnt_r;
    wire                 rm_smp = ~am_n & ~sel_n;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            match_r  <= 1'b0;
            rmatch_r <= 1'b0;
            forced_r <= 1'b0;
            clear_r  <= 1'b0;
            cnt_r    <= {`RST_CNT_W{1'b0}};
        end
        else
        begin
            clear_r <= 1'b0;
            if (edge_en)
            begin
                match_r  <= ~am_n & sel_n;
                rmatch_r <= rm_smp;
                if (!rm_smp)
                begin
                    // an early drop aborts; a late drop lets the reset proceed
                    cnt_r <= {`RST_CNT_W{1'b0}};
                    if (forced_r)
                        clear_r <= 1'b1;
                    forced_r <= 1'b0;
                end
                else if (!hold && !block && !forced_r)
                begin
                    if (cnt_r == `RST_SEQ_LEN - 4'h1)
                        forced_r <= 1'b1;
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end

endmodule // fifo_reset_seq

// *** core/two_entry_buf.v ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps

module two_entry_buf
#(
    parameter DW = 12
)
(
    input  wire          clk,
    input  wire          rst_n,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [DW-1:0] in_data,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [DW-1:0] out_data
);

    reg [DW-1:0] mem_r [0:1];
    reg          wp_r;
    reg          rp_r;
    reg [1:0]    cnt_r;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];

    always @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end
        else
        begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // two_entry_buf

// *** core/host_port_sel.v ***
// host port selection, flag drivers and fifo reset control
//
// Notes on behaviour
// - receive match when address matched, not resetting
// - receive flags driven only in match states
// - fifo mode: enable falling during match selects
// - selected receive reads fifo onto data bus
// - bypass non-packed: receive clock becomes character output
// - bypass: match first, enable later selects
// - reselect needs fresh match; unselected bus floats
// - bypass receive flags follow address match only
// - match and enable at reset give continuous selection
// - continuous selection blocks fifo resets
// - transmit reset match when both low
// - receive reset match when both low
// - reset needs eight consecutive match cycles
// - active enable holds off that reset
// - both fifos cleared at power-up
// - transmit reset forces full flags
// - reset full blocks writes; normal full does not
// - reset proceeds when host removes condition
// - transmit reset completion shows empty
// - receive reset forces empty flags
// - selection ignored cycle after receive reset release
// - transmit enable polarity depends on cascade timing
// - selected transmit captures data bus into fifo, except in bypass
`timescale 1ns/100ps
`include "port_sel_consts.vh"

module host_port_sel
#(
    parameter DW       = `DATA_W_DEF,
    parameter CHAR_DIV = `CHAR_DIV_DEF
)
(
    input  wire          clk_sys,
    input  wire          resetn,
    input  wire          tx_clock,
    input  wire          rx_clock_i,
    output reg           rx_clock_o,
    output wire          rx_clock_oe,
    input  wire          addr_match_n,
    input  wire          tx_reset_select_n,
    input  wire          rx_reset_select_n,
    input  wire          tx_enable_n,
    input  wire          rx_enable_n,
    input  wire          buffer_bypass_n,
    input  wire          byte_packed,
    input  wire          cascade_timing,
    input  wire [DW-1:0] tx_data_bus,
    output reg  [DW-1:0] tx_word_data,
    output reg           tx_word_valid,
    input  wire          tx_word_ready,
    output wire          tx_write_block,
    input  wire          tx_fifo_empty,
    input  wire          tx_fifo_half,
    input  wire          tx_fifo_full,
    output wire          tx_fifo_clear,
    output reg           tx_empty_flag_n,
    output reg           tx_half_flag_n,
    output reg           tx_full_flag_n,
    output wire          tx_flags_oe,
    input  wire [DW-1:0] rx_word_data,
    input  wire          rx_word_valid,
    output wire          rx_word_ready,
    input  wire          rx_fifo_empty,
    input  wire          rx_fifo_full,
    output wire          rx_fifo_clear,
    output reg  [DW-1:0] rx_data_bus,
    output wire          rx_data_oe,
    output reg           rx_empty_flag_n,
    output reg           rx_full_flag_n,
    output wire          rx_flags_oe,
    output wire          tx_selected,
    output wire          rx_selected
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_s1_r;
    reg rst_n_r;

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ----------------------------------------
    // interface clock edges and character clock
    // ----------------------------------------
    reg                  txc_d_r;
    reg                  rxc_d_r;
    reg [`CHAR_DIV_W-1:0] div_r;
    reg                  gen_rise_r;
    wire                 bypass = ~buffer_bypass_n & ~byte_packed;

    assign rx_clock_oe = bypass;

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            txc_d_r    <= 1'b0;
            rxc_d_r    <= 1'b0;
            div_r      <= {`CHAR_DIV_W{1'b0}};
            rx_clock_o <= 1'b0;
            gen_rise_r <= 1'b0;
        end
        else
        begin
            txc_d_r    <= tx_clock;
            rxc_d_r    <= rx_clock_i;
            gen_rise_r <= 1'b0;
            if (div_r == CHAR_DIV - `CHAR_DIV_W'h1)
            begin
                div_r      <= {`CHAR_DIV_W{1'b0}};
                rx_clock_o <= ~rx_clock_o;
                gen_rise_r <= ~rx_clock_o;
            end
            else
                div_r <= div_r + `CHAR_DIV_W'h1;
        end
    end

    // each side samples the inputs only on its own clock rising edge
    wire tx_edge = tx_clock & ~txc_d_r;
    wire rx_edge = bypass ? gen_rise_r : (rx_clock_i & ~rxc_d_r);

    // ----------------------------------------
    // continuous selection caught while reset is held
    // ----------------------------------------
    reg tx_cont_r;
    reg rx_cont_r;

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_cont_r <= 1'b0;
            rx_cont_r <= 1'b0;
        end
        else if (!rst_n_r)
        begin
            tx_cont_r <= ~addr_match_n & ~tx_enable_n;
            rx_cont_r <= ~addr_match_n & ~rx_enable_n;
        end
        else
        begin
            if (tx_edge && (addr_match_n || tx_enable_n))
                tx_cont_r <= 1'b0;
            if (rx_edge && (addr_match_n || rx_enable_n))
                rx_cont_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // match and reset sequencers
    // ----------------------------------------
    wire tx_match;
    wire tx_rmatch;
    wire tx_forced;
    wire tx_clr;
    wire rx_match;
    wire rx_rmatch;
    wire rx_forced;
    wire rx_clr;
    // enable level that inhibits the transmit reset
    wire tx_en_act = cascade_timing ? ~tx_enable_n : tx_enable_n;

    fifo_reset_seq u_tx_seq
    (
        .clk      (clk_sys),
        .rst_n    (rst_n_r),
        .edge_en  (tx_edge),
        .am_n     (addr_match_n),
        .sel_n    (tx_reset_select_n),
        .hold     (tx_en_act),
        .block    (tx_cont_r),
        .match_r  (tx_match),
        .rmatch_r (tx_rmatch),
        .forced_r (tx_forced),
        .clear_r  (tx_clr)
    );

    fifo_reset_seq u_rx_seq
    (
        .clk      (clk_sys),
        .rst_n    (rst_n_r),
        .edge_en  (rx_edge),
        .am_n     (addr_match_n),
        .sel_n    (rx_reset_select_n),
        .hold     (~rx_enable_n),
        .block    (rx_cont_r),
        .match_r  (rx_match),
        .rmatch_r (rx_rmatch),
        .forced_r (rx_forced),
        .clear_r  (rx_clr)
    );

    // power-up clear covers the whole synchronised reset
    assign tx_fifo_clear = ~rst_n_r | tx_clr;
    assign rx_fifo_clear = ~rst_n_r | rx_clr;

    // ----------------------------------------
    // sampled history per side
    // ----------------------------------------
    reg tx_en_d_r;
    reg rx_en_d_r;
    reg rx_am_r;
    reg rx_inhibit_r;

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_en_d_r    <= 1'b1;
            rx_en_d_r    <= 1'b1;
            rx_am_r      <= 1'b0;
            rx_inhibit_r <= 1'b0;
        end
        else
        begin
            if (tx_edge)
                tx_en_d_r <= tx_enable_n;
            if (rx_edge)
            begin
                rx_en_d_r <= rx_enable_n;
                rx_am_r   <= ~addr_match_n;
                // a selection in the cycle after reset release is lost
                // until the enable goes high again
                if (rx_forced && rx_reset_select_n)
                    rx_inhibit_r <= 1'b1;
                else if (rx_enable_n)
                    rx_inhibit_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // selection states
    // ----------------------------------------
    reg tx_sel_r;
    reg rx_sel_r;
    wire rx_block = rx_inhibit_r | (rx_forced & rx_reset_select_n);
    wire rx_start = bypass ? (rx_am_r & ~rx_enable_n)
                           : (rx_match & rx_en_d_r & ~rx_enable_n);

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_sel_r <= 1'b0;
            rx_sel_r <= 1'b0;
        end
        else
        begin
            if (tx_edge)
            begin
                if (tx_enable_n)
                    tx_sel_r <= 1'b0;
                else if (tx_match && tx_en_d_r)
                    tx_sel_r <= 1'b1;
            end
            if (rx_edge)
            begin
                if (rx_enable_n)
                    rx_sel_r <= 1'b0;
                else if (rx_start && !rx_block)
                    rx_sel_r <= 1'b1;
            end
        end
    end

    assign tx_selected = tx_sel_r | tx_cont_r;
    assign rx_selected = rx_sel_r | rx_cont_r;

    // ----------------------------------------
    // transmit capture
    // ----------------------------------------
    // only the reset-forced full refuses writes; normal full is passed on
    // so the fifo may still take its eight spare words
    assign tx_write_block = tx_forced;

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_word_valid <= 1'b0;
            tx_word_data  <= {DW{1'b0}};
        end
        else
        begin
            if (tx_word_ready)
                tx_word_valid <= 1'b0;
            if (tx_edge && !tx_enable_n && (tx_selected || (tx_match && tx_en_d_r))
                && !tx_forced && !bypass)
            begin
                tx_word_valid <= 1'b1;
                tx_word_data  <= tx_data_bus;
            end
        end
    end

    // ----------------------------------------
    // receive read path
    // ----------------------------------------
    wire          buf_valid;
    wire [DW-1:0] buf_data;
    wire          rd_take = rx_edge & rx_selected & ~rx_enable_n;

    two_entry_buf #(.DW(DW)) u_rx_buf
    (
        .clk       (clk_sys),
        .rst_n     (rst_n_r),
        .in_valid  (rx_word_valid & ~rx_forced),
        .in_ready  (rx_word_ready),
        .in_data   (rx_word_data),
        .out_valid (buf_valid),
        .out_ready (rd_take),
        .out_data  (buf_data)
    );

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            rx_data_bus <= {DW{1'b0}};
        else if (rd_take && buf_valid)
            rx_data_bus <= buf_data;
    end

    assign rx_data_oe = rx_selected;

    // ----------------------------------------
    // flag drivers
    // ----------------------------------------
    assign tx_flags_oe = tx_match | tx_rmatch;
    assign rx_flags_oe = bypass ? rx_am_r
                                : (rx_match | rx_rmatch);

    always @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_empty_flag_n <= 1'b1;
            tx_half_flag_n  <= 1'b0;
            tx_full_flag_n  <= 1'b0;
            rx_empty_flag_n <= 1'b0;
            rx_full_flag_n  <= 1'b1;
        end
        else
        begin
            if (tx_forced)
            begin
                tx_empty_flag_n <= 1'b1;
                tx_half_flag_n  <= 1'b0;
                tx_full_flag_n  <= 1'b0;
            end
            else
            begin
                // once cleared the fifo reports empty, marking completion
                tx_empty_flag_n <= ~tx_fifo_empty;
                tx_half_flag_n  <= ~tx_fifo_half;
                tx_full_flag_n  <= ~tx_fifo_full;
            end
            if (rx_forced)
            begin
                rx_empty_flag_n <= 1'b0;
                rx_full_flag_n  <= 1'b1;
            end
            else
            begin
                rx_empty_flag_n <= ~(rx_fifo_empty & ~buf_valid);
                rx_full_flag_n  <= ~rx_fifo_full;
            end
        end
    end

endmodule // host_port_sel

// *** verif/host_port_sel_checker.sv ***
// concurrent checks on the host port selection block
`timescale 1ns/100ps
module host_port_sel_checker
#(
    parameter DW       = 12,
    parameter CHAR_DIV = 8'h04
)
(
    input wire clk_sys,
    input wire resetn,
    input wire tx_clock,
    input wire rx_clock_i,
    input wire addr_match_n,
    input wire tx_reset_select_n,
    input wire rx_reset_select_n,
    input wire tx_enable_n,
    input wire rx_enable_n,
    input wire buffer_bypass_n,
    input wire tx_write_block,
    input wire tx_fifo_clear,
    input wire tx_word_valid,
    input wire tx_empty_flag_n,
    input wire tx_half_flag_n,
    input wire tx_full_flag_n,
    input wire tx_flags_oe,
    input wire tx_selected,
    input wire rx_empty_flag_n,
    input wire rx_flags_oe,
    input wire rx_selected
);
    reg       txc_r;
    reg       rxc_r;
    reg [3:0] tcnt_r;
    reg [3:0] rcnt_r;
    wire      tx_e = tx_clock & ~txc_r;
    wire      rx_e = rx_clock_i & ~rxc_r & buffer_bypass_n;
    wire      t_rm = ~addr_match_n & ~tx_reset_select_n;
    wire      r_rm = ~addr_match_n & ~rx_reset_select_n;

    // ----------------------------------------
    // reset-match edge counters, saturating at eight
    // ----------------------------------------
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            txc_r  <= 1'b0;
            rxc_r  <= 1'b0;
            tcnt_r <= 4'h0;
            rcnt_r <= 4'h0;
        end
        else
        begin
            txc_r <= tx_clock;
            rxc_r <= rx_clock_i;
            if (tx_e && (!tx_enable_n || !t_rm))
                tcnt_r <= t_rm ? tcnt_r + {3'h0, tcnt_r != 4'h8} : 4'h0;
            // an active receive enable freezes the count instead of clearing it
            if (rx_e && (rx_enable_n || !r_rm))
                rcnt_r <= r_rm ? rcnt_r + {3'h0, rcnt_r != 4'h8} : 4'h0;
        end
    end

    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_rx_am;
        rx_e && !addr_match_n;
    endsequence
    sequence s_tx_full;
        tx_empty_flag_n && !tx_half_flag_n && !tx_full_flag_n;
    endsequence

    AST_RX_FLAGS_ON: assert property (s_rx_am |-> ##[1:2] rx_flags_oe)
        else $error("rx flags not driven");
    AST_RX_FLAGS_OFF: assert property (rx_e && addr_match_n |-> ##[1:2] !rx_flags_oe)
        else $error("rx flags not floated");
    AST_TX_FLAGS_ON: assert property (tx_e && !addr_match_n |-> ##[1:2] tx_flags_oe)
        else $error("tx flags not driven");
    AST_TX_FLAGS_OFF: assert property (tx_e && addr_match_n |-> ##[1:2] !tx_flags_oe)
        else $error("tx flags not floated");
    AST_RX_SEL_END: assert property (rx_e && rx_enable_n |-> ##[1:2] !rx_selected)
        else $error("rx stays selected");
    AST_TX_SEL_END: assert property (tx_e && tx_enable_n |-> ##[1:2] !tx_selected)
        else $error("tx stays selected");
    AST_TX_COUNT: assert property ($rose(tx_write_block) |-> tcnt_r == 4'h8)
        else $error("tx reset without eight edges");
    AST_TX_FORCED: assert property (tx_write_block && $past(tx_write_block) |-> s_tx_full)
        else $error("tx flags not forced full");
    AST_TX_NO_WRITE: assert property (tx_write_block |-> !$rose(tx_word_valid))
        else $error("tx word during reset full");
    AST_TX_CLEAR: assert property ($fell(tx_write_block) |-> ##[0:2] tx_fifo_clear)
        else $error("tx clear missing on release");
    AST_RX_FORCED: assert property (rcnt_r == 4'h8 |-> ##[0:2] !rx_empty_flag_n)
        else $error("rx flags not forced empty");
endmodule // host_port_sel_checker

bind host_port_sel host_port_sel_checker #(.DW(DW), .CHAR_DIV(CHAR_DIV)) u_checker
(
    .clk_sys, .resetn, .tx_clock, .rx_clock_i, .addr_match_n, .tx_reset_select_n,
    .rx_reset_select_n, .tx_enable_n, .rx_enable_n, .buffer_bypass_n, .tx_write_block,
    .tx_fifo_clear, .tx_word_valid, .tx_empty_flag_n, .tx_half_flag_n, .tx_full_flag_n,
    .tx_flags_oe, .tx_selected, .rx_empty_flag_n, .rx_flags_oe, .rx_selected
);

// *** verif/fifo_side_model.sv ***
// behavioural model of the internal fifos behind the host port
`timescale 1ns/100ps
module fifo_side_model
(
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire [11:0] tx_word_data,
    input  wire        tx_word_valid,
    output logic       tx_word_ready,
    input  wire        tx_fifo_clear,
    output wire        tx_fifo_empty,
    output wire        tx_fifo_half,
    output wire        tx_fifo_full,
    output wire [11:0] rx_word_data,
    output logic       rx_word_valid,
    input  wire        rx_word_ready,
    output wire        rx_fifo_empty,
    output wire        rx_fifo_full
);
    logic [11:0] tx_q[$];
    logic [8:0]  n_tx;
    logic [11:0] rx_cnt;
    // an idle data line shows the inverse so a stale word never looks fresh
    assign rx_word_data  = rx_word_valid ? rx_cnt : ~rx_cnt;
    assign tx_fifo_empty = (n_tx == 9'h000);
    assign tx_fifo_half  = n_tx[7];
    assign tx_fifo_full  = n_tx[8];
    assign rx_fifo_empty = 1'b0;
    assign rx_fifo_full  = 1'b0;

    // ready stalls every other cycle, the source pauses after each word
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_word_ready <= 1'b0;
            rx_word_valid <= 1'b0;
            rx_cnt        <= 12'h000;
            n_tx          <= 9'h000;
        end
        else
        begin
            tx_word_ready <= ~tx_word_ready;
            if (tx_fifo_clear)
            begin
                tx_q.delete();
                n_tx <= 9'h000;
            end
            else if (tx_word_valid && tx_word_ready)
            begin
                tx_q.push_back(tx_word_data);
                n_tx <= n_tx + 9'h001;
            end
            if (rx_word_valid && rx_word_ready)
            begin
                rx_word_valid <= 1'b0;
                rx_cnt        <= rx_cnt + 12'h001;
            end
            else
                rx_word_valid <= 1'b1;
        end
    end
endmodule // fifo_side_model

// *** verif/host_port_sel_bench.sv ***
// self-checking bench for the host port selection block
`timescale 1ns/100ps
module host_port_sel_bench;
    logic        clk_sys = 1'b0;
    logic        resetn, tx_clock, rx_clock_i, addr_match_n, buffer_bypass_n;
    logic        tx_reset_select_n, rx_reset_select_n, tx_enable_n, rx_enable_n;
    logic [11:0] tx_data_bus, v;
    logic        b, ct = 1'b0;
    int          miscompares = 0;
    int          n_checks = 0;
    wire [11:0]  tx_word_data, rx_word_data, rx_data_bus;
    wire         rx_clock_o, rx_clock_oe, tx_word_valid, tx_word_ready, tx_write_block;
    wire         tx_fifo_empty, tx_fifo_half, tx_fifo_full, tx_fifo_clear, tx_flags_oe;
    wire         tx_empty_flag_n, tx_half_flag_n, tx_full_flag_n, rx_word_valid;
    wire         rx_word_ready, rx_fifo_empty, rx_fifo_full, rx_fifo_clear, rx_data_oe;
    wire         rx_empty_flag_n, rx_full_flag_n, rx_flags_oe, tx_selected, rx_selected;

    always #2.5 clk_sys = ~clk_sys;

    host_port_sel #(.DW(12), .CHAR_DIV(8'h01)) u_dut
    (
        .clk_sys, .resetn, .tx_clock, .rx_clock_i, .rx_clock_o, .rx_clock_oe,
        .addr_match_n, .tx_reset_select_n, .rx_reset_select_n, .tx_enable_n,
        .rx_enable_n, .buffer_bypass_n, .byte_packed(1'b0), .cascade_timing(ct),
        .tx_data_bus, .tx_word_data, .tx_word_valid, .tx_word_ready, .tx_write_block,
        .tx_fifo_empty, .tx_fifo_half, .tx_fifo_full, .tx_fifo_clear, .tx_empty_flag_n,
        .tx_half_flag_n, .tx_full_flag_n, .tx_flags_oe, .rx_word_data, .rx_word_valid,
        .rx_word_ready, .rx_fifo_empty, .rx_fifo_full, .rx_fifo_clear, .rx_data_bus,
        .rx_data_oe, .rx_empty_flag_n, .rx_full_flag_n, .rx_flags_oe, .tx_selected,
        .rx_selected
    );

    fifo_side_model u_model
    (
        .clk_sys, .resetn, .tx_word_data, .tx_word_valid, .tx_word_ready, .tx_fifo_clear,
        .tx_fifo_empty, .tx_fifo_half, .tx_fifo_full, .rx_word_data, .rx_word_valid,
        .rx_word_ready, .rx_fifo_empty, .rx_fifo_full
    );

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    // one interface clock period of five system cycles, t high for transmit
    task automatic pulse(input bit t, input int n);
        repeat (n)
        begin
            step;
            tx_clock = t;
            rx_clock_i = !t;
            repeat (2) step;
            tx_clock = 1'b0;
            rx_clock_i = 1'b0;
            repeat (2) step;
        end
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic am, input logic ten);
        resetn = 1'b0;
        addr_match_n = am;
        tx_enable_n = ten;
        repeat (5) step;
        chk(tx_fifo_clear, 1'b1);
        chk(rx_fifo_clear, 1'b1);
        resetn = 1'b1;
        repeat (4) step;
    endtask

    task automatic t_tx_write;
        pulse(1, 1);
        chk(tx_flags_oe, 1'b0);
        addr_match_n = 1'b0;
        pulse(1, 1);
        chk(tx_flags_oe, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            tx_enable_n = 1'b0;
            tx_data_bus = 12'h100 | 12'(i);
            pulse(1, 1);
        end
        chk(tx_selected, 1'b1);
        tx_enable_n = 1'b1;
        tx_data_bus = 12'h0ff;
        pulse(1, 1);
        chk(tx_selected, 1'b0);
        chk(u_model.tx_q[$], 12'h103);
        chk(u_model.tx_q[u_model.tx_q.size() - 2], 12'h102);
    endtask

    task automatic t_tx_reset;
        tx_reset_select_n = 1'b0;
        pulse(1, 1);
        tx_enable_n = 1'b0;
        pulse(1, 7);
        chk(tx_write_block, 1'b0);
        pulse(1, 1);
        chk(tx_write_block, 1'b1);
        chk({tx_empty_flag_n, tx_half_flag_n, tx_full_flag_n}, 3'b100);
        tx_reset_select_n = 1'b1;
        pulse(1, 1);
        repeat (2) step;
        chk({tx_empty_flag_n, tx_half_flag_n, tx_full_flag_n, tx_flags_oe}, 4'h7);
        ct = 1'b1;
        tx_reset_select_n = 1'b0;
        pulse(1, 9);
        chk(tx_write_block, 1'b0);
        ct = 1'b0;
        tx_reset_select_n = 1'b1;
        tx_enable_n = 1'b1;
    endtask

    task automatic t_rx_read;
        addr_match_n = 1'b1;
        pulse(0, 1);
        repeat (6) step;
        chk(rx_data_oe, 1'b0);
        chk(rx_word_ready, 1'b0); // both entries full while unselected
        addr_match_n = 1'b0;
        pulse(0, 1);
        rx_enable_n = 1'b0;
        pulse(0, 2);
        chk(rx_data_oe, 1'b1);
        v = rx_data_bus;
        pulse(0, 1);
        chk(rx_data_bus, v + 12'h001);
        pulse(0, 1);
        chk(rx_data_bus, v + 12'h002);
        rx_enable_n = 1'b1;
        pulse(0, 1);
        chk(rx_selected, 1'b0);
    endtask

    task automatic t_rx_reset;
        rx_reset_select_n = 1'b0;
        pulse(0, 1);
        rx_enable_n = 1'b0;
        pulse(0, 9);
        chk(rx_empty_flag_n, 1'b1);
        rx_enable_n = 1'b1;
        pulse(0, 4);
        rx_reset_select_n = 1'b1;
        pulse(0, 1);
        rx_reset_select_n = 1'b0;
        pulse(0, 7);
        chk(rx_empty_flag_n, 1'b1);
        pulse(0, 1);
        chk({rx_empty_flag_n, rx_full_flag_n, rx_flags_oe}, 3'b011);
        rx_reset_select_n = 1'b1;
        pulse(0, 1);
        rx_enable_n = 1'b0;
        pulse(0, 1);
        chk(rx_selected, 1'b0);
        rx_enable_n = 1'b1;
        pulse(0, 1);
        rx_enable_n = 1'b0;
        pulse(0, 1);
        chk(rx_selected, 1'b1);
        rx_enable_n = 1'b1;
        pulse(0, 1);
    endtask

    task automatic t_bypass;
        buffer_bypass_n = 1'b0;
        repeat (6) step;
        chk(rx_clock_oe, 1'b1);
        b = rx_clock_o;
        step;
        chk(rx_clock_o, !b);
        chk(rx_flags_oe, 1'b1);
        rx_enable_n = 1'b0;
        repeat (6) step;
        addr_match_n = 1'b1;
        repeat (6) step;
        chk({rx_selected, rx_flags_oe}, 2'b10);
        rx_enable_n = 1'b1;
        repeat (6) step;
        chk(rx_data_oe, 1'b0);
        buffer_bypass_n = 1'b1;
    endtask

    task automatic t_continuous;
        do_reset(1'b0, 1'b0);
        chk(tx_selected, 1'b1);
        tx_reset_select_n = 1'b0;
        pulse(1, 10);
        chk(tx_write_block, 1'b0);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        tx_clock = 1'b0;
        rx_clock_i = 1'b0;
        tx_reset_select_n = 1'b1;
        rx_reset_select_n = 1'b1;
        rx_enable_n = 1'b1;
        buffer_bypass_n = 1'b1;
        tx_data_bus = 12'h000;
        do_reset(1'b1, 1'b1);
        t_tx_write;
        t_tx_reset;
        t_rx_read;
        t_rx_reset;
        t_bypass;
        t_continuous;
        report_and_stop;
    end

    initial
    begin
        #50000;
        miscompares++;
        report_and_stop;
    end
endmodule // host_port_sel_bench
